// File: src/pack_monitor_i2c_slave_regs.sv
// two-wire slave port with register file and feature-set write protection
// Function
// - data changes only while clock low
// - falling data with clock high is start
// - rising data with clock high is stop
// - receiver pulls data low on ninth clock
// - acknowledge only matching slave byte, all others
// - read: send byte, sample ack, continue/stop
// - load data at falling clock after bit eight
// - pointer increments after write, wraps past top
// - read data shifted out msb first
// - pointer increments after each read byte
// - current-address read uses retained pointer
// - feature-set register locked until enable bit set
// - device is always slave, master clocks
// - all bytes travel msb first
`timescale 1ns/10ps
`include "pack_monitor_map.svh"
module pack_monitor_i2c_slave_regs
    import pack_monitor_pkg::*;
#(
    parameter int NUM_REGS = 11
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [6:0] slave_addr_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic feature_set_write_enable_o,
    output logic [7:0] feature_set_config_o,
    output logic busy_o
);
    // ****************************************
    // line synchronisers and edge detection
    // ****************************************
    bus_lines_t sync1; // first stage, read only by second
    bus_lines_t sync2; // second stage
    bus_lines_t prev; // last settled sample
    bus_lines_t next_sync1, next_sync2, next_prev; // next values of the chain
    logic scl_rise, scl_fall, start_det, stop_det;

    // next values of the sampling chain; only the second stage reads the first
    always_comb begin
        next_sync1 = '{scl: scl_i, sda: sda_i};
        next_sync2 = sync1;
        next_prev = sync2;
    end

    // two flops per line; the third stage gives edges without touching sync1
    // reset to high so idle lines show no false edge after release
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1 <= '1;
            sync2 <= '1;
            prev <= '1;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev <= next_prev;
        end
    end

    // edges of the master's clock; master always owns it
    assign scl_rise = sync2.scl & ~prev.scl;
    assign scl_fall = ~sync2.scl & prev.scl;
    // data moving while clock is high marks start or stop
    assign start_det = prev.scl & sync2.scl & prev.sda & ~sync2.sda;
    assign stop_det = prev.scl & sync2.scl & ~prev.sda & sync2.sda;

    // pointer step with wrap after the top register
    function automatic logic [3:0] ptr_step(input logic [3:0] p);
        ptr_step = (p >= `REG_TOP_ADDR) ? 4'h0 : p + 4'h1;
    endfunction

    // ****************************************
    // protocol state machine
    // ****************************************
    slv_state_t state, next_state;
    logic [3:0] bitcnt, next_bitcnt; // 0..7 data bits, 8 = ack slot
    logic [7:0] shreg, next_shreg; // shift register, msb first
    logic [3:0] ptr, next_ptr; // register pointer
    logic rd_mode, next_rd_mode; // slave byte asked for a read
    logic acking, next_acking; // we hold data low in the ack slot
    logic matched, next_matched; // slave byte matched this frame
    sda_drive_t drv, next_drv;
    logic [7:0] regs [NUM_REGS]; // register storage
    logic [7:0] next_regs [NUM_REGS];
    logic [7:0] rd_byte;

    // readback of the addressed register; unmapped reads as zero
    assign rd_byte = (ptr < 4'(NUM_REGS)) ? regs[ptr] : 8'h00;

    // next-state logic: received bits shift on rising clock, drive changes on falling
    always_comb begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_rd_mode = rd_mode;
        next_acking = acking;
        next_matched = matched;
        next_drv = drv;
        for (int i = 0; i < NUM_REGS; i++) begin
            next_regs[i] = regs[i];
        end
        if (start_det) begin
            // start or repeated start restarts the byte machine
            next_state = ST_SLAVE;
            next_bitcnt = 4'h0;
            next_acking = 1'b0;
            next_matched = 1'b0;
            next_drv = '{out: 1'b1, oe: 1'b0};
        end else if (stop_det) begin
            // stop returns to standby and releases the line
            next_state = ST_IDLE;
            next_acking = 1'b0;
            next_drv = '{out: 1'b1, oe: 1'b0};
        end else if (state != ST_IDLE) begin
            if (scl_rise) begin
                if (bitcnt < 4'h8) begin
                    // receive msb first; while reading the shifter belongs to the
                    // falling edge, shifting here too would skip every other bit
                    if (state != ST_RDATA) begin
                        next_shreg = {shreg[6:0], sync2.sda};
                    end
                    next_bitcnt = bitcnt + 4'h1;
                end else if (state == ST_ACKCHK) begin
                    // master's acknowledge decides whether to continue
                    if (sync2.sda) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_state = ST_RDATA;
                    end
                    next_bitcnt = 4'h0;
                end else begin
                    next_bitcnt = 4'h0;
                end
            end else if (scl_fall) begin
                if (bitcnt == 4'h8 && state != ST_ACKCHK && !acking) begin
                    // falling edge after eighth bit: act on the byte
                    unique case (state)
                        ST_SLAVE: begin
                            if (shreg[7:1] == slave_addr_i) begin
                                next_acking = 1'b1;
                                next_matched = 1'b1;
                                next_rd_mode = shreg[0];
                                next_drv = '{out: 1'b0, oe: 1'b1};
                            end else begin
                                next_state = ST_IDLE;
                            end
                        end
                        ST_ADDR: begin
                            next_ptr = shreg[3:0];
                            next_acking = 1'b1;
                            next_drv = '{out: 1'b0, oe: 1'b1};
                        end
                        ST_WDATA: begin
                            // feature-set register only moves while unlocked
                            if (ptr < 4'(NUM_REGS)) begin
                                if (ptr != `REG_FEATURE_SET_CONFIG ||
                                    regs[`REG_WRITE_ENABLE_CONTROL][`FSET_WE_BIT]) begin
                                    next_regs[ptr] = shreg;
                                end
                            end
                            next_acking = 1'b1;
                            next_drv = '{out: 1'b0, oe: 1'b1};
                        end
                        ST_RDATA: begin
                            // byte sent: release line, step pointer
                            next_drv = '{out: 1'b1, oe: 1'b0};
                            next_ptr = ptr_step(ptr);
                            next_state = ST_ACKCHK;
                        end
                        default: begin
                            next_state = ST_IDLE;
                        end
                    endcase
                end else if (acking) begin
                    // end of our ack slot: choose what follows
                    next_acking = 1'b0;
                    next_drv = '{out: 1'b1, oe: 1'b0};
                    unique case (state)
                        ST_SLAVE: begin
                            // read starts from the retained pointer
                            next_state = rd_mode ? ST_RDATA : ST_ADDR;
                        end
                        ST_ADDR: begin
                            next_state = ST_WDATA;
                        end
                        ST_WDATA: begin
                            next_ptr = ptr_step(ptr);
                        end
                        default: begin
                            next_state = state;
                        end
                    endcase
                    if (state == ST_SLAVE && rd_mode) begin
                        // first read bit goes out right at this low phase
                        next_drv = '{out: rd_byte[7], oe: ~rd_byte[7]};
                        next_shreg = {rd_byte[6:0], 1'b0};
                    end
                end else if (state == ST_RDATA && bitcnt < 4'h8) begin
                    // drive next bit while clock is low; open drain, so high releases
                    if (bitcnt == 4'h0) begin
                        next_drv = '{out: rd_byte[7], oe: ~rd_byte[7]};
                        next_shreg = {rd_byte[6:0], 1'b0};
                    end else begin
                        next_drv = '{out: shreg[7], oe: ~shreg[7]};
                        next_shreg = {shreg[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // state and datapath registers; reset clears protection and pointer
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 4'h0;
            rd_mode <= 1'b0;
            acking <= 1'b0;
            matched <= 1'b0;
            drv <= '{out: 1'b1, oe: 1'b0};
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= `REG_RESET_VALUE;
            end
        end else begin
            state <= next_state;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            rd_mode <= next_rd_mode;
            acking <= next_acking;
            matched <= next_matched;
            drv <= next_drv;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= next_regs[i];
            end
        end
    end

    // outputs: open-drain style, only low is ever driven
    assign sda_o = 1'b0;
    assign sda_oe_o = drv.oe;
    assign feature_set_write_enable_o = regs[`REG_WRITE_ENABLE_CONTROL][`FSET_WE_BIT];
    assign feature_set_config_o = regs[`REG_FEATURE_SET_CONFIG];
    assign busy_o = (state != ST_IDLE);

    // ****************************************
    // assertions
    // ****************************************
    a_idle_no_drive: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == ST_IDLE) |-> !drv.oe)
        else $error("data line driven while idle");
    a_stop_to_idle: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        stop_det |=> (state == ST_IDLE) && !sda_oe_o)
        else $error("stop did not return to idle");
    a_drive_on_low: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $changed(drv.oe) |-> !sync2.scl)
        else $error("data drive changed while clock high");
    a_mismatch_nack: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == ST_SLAVE && scl_fall && bitcnt == 4'h8 && !acking && !start_det
         && !stop_det && shreg[7:1] != slave_addr_i) |=> !sda_oe_o && state == ST_IDLE)
        else $error("mismatched slave byte acknowledged");
    a_lock_holds: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !feature_set_write_enable_o |=> $stable(feature_set_config_o))
        else $error("locked feature-set register changed");
    a_read_step: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == ST_RDATA && next_state == ST_ACKCHK) |=> ptr == ptr_step($past(ptr)))
        else $error("pointer did not step after read byte");
    a_nack_ends: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == ST_ACKCHK && scl_rise && sync2.sda && !start_det && !stop_det)
        |=> state == ST_IDLE ##1 !sda_oe_o)
        else $error("read continued after nack");
    a_ack_release: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $rose(acking) |-> ##[1:1000] !acking)
        else $error("acknowledge held too long");
    a_wait_start: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == ST_IDLE && !start_det) |=> state == ST_IDLE)
        else $error("left idle without a start");
    a_od_low_only: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        drv.oe |-> !drv.out)
        else $error("data line drive enabled with a high level");
    a_ack_matched: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        acking |-> matched)
        else $error("acknowledge given without a matching slave byte");
    c_write: cover property (@(posedge clk_sys_i) state == ST_WDATA && acking);
    c_read: cover property (@(posedge clk_sys_i) state == ST_ACKCHK);
    c_unlock: cover property (@(posedge clk_sys_i) $rose(feature_set_write_enable_o));
    // master acknowledged a read byte and asked for the next register
    c_read_more: cover property (@(posedge clk_sys_i)
        state == ST_ACKCHK && next_state == ST_RDATA);
    // a slave byte for some other device
    c_foreign: cover property (@(posedge clk_sys_i)
        state == ST_SLAVE && next_state == ST_IDLE && !stop_det);
endmodule

// File: src/pack_monitor_map.svh
// register offsets, field positions and bus constants of the pack monitor slave port
`ifndef PACK_MONITOR_MAP_SVH
`define PACK_MONITOR_MAP_SVH
`define REG_FEATURE_SET_CONFIG 4'h7
`define REG_WRITE_ENABLE_CONTROL 4'h8
`define REG_TOP_ADDR 4'ha
`define FSET_WE_BIT 7
`define SLAVE_ADDR_DEFAULT 7'h28
`define REG_RESET_VALUE 8'h00
`endif

// File: src/pack_monitor_pkg.sv
// types shared by the pack monitor slave port
package pack_monitor_pkg;
    // protocol states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_SLAVE = 6'b000010,
        ST_ADDR = 6'b000100,
        ST_WDATA = 6'b001000,
        ST_RDATA = 6'b010000,
        ST_ACKCHK = 6'b100000
    } slv_state_t;
    // synchronised bus line samples
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_lines_t;
    // data line drive: output value and enable
    typedef struct packed {
        logic out;
        logic oe;
    } sda_drive_t;
endpackage

// File: sim/i2c_master_model.sv
// two-wire bus master model that clocks the slave port
`timescale 1ns/10ps
module i2c_master_model (
    input wire logic clk_sys_i,
    input wire logic sda_w_i,
    output logic scl_o,
    output logic sda_m_o
);
    // ****************
    // bus phases
    // ****************
    // both lines released while idle
    initial begin
        scl_o = 1'b1;
        sda_m_o = 1'b1;
    end
    // step n system clocks, then just past the edge
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // pull the clock low with data high, which is neither start nor stop
    task automatic lo();
        scl_o = 1'b0;
        w(3);
    endtask
    // start or repeated start; only the master opens a frame
    task automatic start();
        sda_m_o = 1'b1;
        w(2);
        scl_o = 1'b1;
        w(4);
        sda_m_o = 1'b0;
        w(4);
        scl_o = 1'b0;
        w(3);
    endtask
    // stop, issued after the transmitter has let go
    task automatic stop();
        sda_m_o = 1'b0;
        w(2);
        scl_o = 1'b1;
        w(4);
        sda_m_o = 1'b1;
        w(6);
    endtask
    // one bit: data set in the low half, sampled at the end of the high half
    task automatic xfer_bit(input logic b, output logic s);
        sda_m_o = b;
        w(2);
        scl_o = 1'b1;
        w(5);
        s = sda_w_i;
        scl_o = 1'b0;
        w(3);
    endtask
    // send a byte, msb first, and report the slave's acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xfer_bit(d[i], s);
        xfer_bit(1'b1, s);
        ack = ~s;
    endtask
    // read a byte; a low ninth bit asks for more, high ends the read
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
        xfer_bit(~ack, s);
    endtask
endmodule

// File: sim/pack_monitor_i2c_slave_regs_tb.sv
// self-checking bench for the pack monitor slave port
`timescale 1ns/10ps
`include "pack_monitor_map.svh"
module pack_monitor_i2c_slave_regs_tb import pack_monitor_pkg::*;;
    // ****************
    // harness
    // ****************
    localparam logic [7:0] SW = {`SLAVE_ADDR_DEFAULT, 1'b0}; // write slave byte
    localparam logic [7:0] SR = {`SLAVE_ADDR_DEFAULT, 1'b1}; // read slave byte
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic scl, sda_m, sda_o, sda_oe_o, fse, busy;
    logic [7:0] fsc;
    wire sda_w = sda_m & ~(sda_oe_o & ~sda_o); // pull-up wins unless pulled
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;
    logic [7:0] mem [0:10]; // expected register contents
    always #4 clk_sys_i = ~clk_sys_i;
    pack_monitor_i2c_slave_regs u_pack_monitor_i2c_slave_regs (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w),
        .slave_addr_i(`SLAVE_ADDR_DEFAULT), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .feature_set_write_enable_o(fse), .feature_set_config_o(fsc), .busy_o(busy));
    i2c_master_model u_master (.clk_sys_i(clk_sys_i), .sda_w_i(sda_w), .scl_o(scl),
        .sda_m_o(sda_m));
    // pointer step with wrap after the top register
    function automatic logic [3:0] step(input logic [3:0] p);
        return (p == `REG_TOP_ADDR) ? 4'h0 : p + 4'h1;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // send a byte and compare the acknowledge with the expectation
    task automatic send(input logic [7:0] b, input logic e);
        logic a;
        u_master.wbyte(b, a);
        chk({7'h0, a}, {7'h0, e});
    endtask
    // single-byte register write frame
    task automatic wr(input logic [3:0] r, input logic [7:0] d);
        u_master.start();
        send(SW, 1'b1);
        send({4'h0, r}, 1'b1);
        send(d, 1'b1);
        u_master.stop();
    endtask
    // hang guard: the run needs well under a third of this
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            print_verdict();
        end
    end
    // main sequence
    initial begin
        logic [7:0] r, v0;
        logic [3:0] p;
        void'($urandom(32'hceef7457));
        repeat (12) @(posedge clk_sys_i);
        #1 sys_rst_i = 1'b0;
        u_master.w(4);
        chk(fsc, 8'h00);
        chk({6'h0, fse, busy}, 8'h00);
        // bits without a start are ignored
        u_master.lo();
        send(SW, 1'b0);
        u_master.stop();
        // foreign slave byte gets no acknowledge
        u_master.start();
        send(SW ^ 8'h04, 1'b0);
        u_master.stop();
        // locked write is acknowledged but dropped
        v0 = 8'($urandom) | 8'h01;
        wr(`REG_FEATURE_SET_CONFIG, v0);
        chk(fsc, 8'h00);
        wr(`REG_WRITE_ENABLE_CONTROL, 8'h80);
        chk({7'h0, fse}, 8'h01);
        // unlocked burst: config then enable register
        u_master.start();
        send(SW, 1'b1);
        send({4'h0, `REG_FEATURE_SET_CONFIG}, 1'b1);
        send(v0, 1'b1);
        chk(fsc, v0);
        send(8'h80, 1'b1);
        u_master.stop();
        chk({7'h0, fse}, 8'h01);
        // the reserved top register is never written, so it keeps its reset value
        mem[4'ha] = `REG_RESET_VALUE;
        for (int k = 0; k < 3; k++) begin
            // burst from the bottom, random data, never past the enable register
            u_master.start();
            send(SW, 1'b1);
            send(8'h00, 1'b1);
            p = 4'h0;
            for (int j = 0; j < 3; j++) begin
                mem[p] = 8'($urandom);
                send(mem[p], 1'b1);
                p = step(p);
            end
            u_master.stop();
            // random read of two registers through the wrap
            u_master.start();
            send(SW, 1'b1);
            send({4'h0, `REG_TOP_ADDR}, 1'b1);
            u_master.start();
            send(SR, 1'b1);
            u_master.rbyte(1'b1, r);
            chk(r, mem[4'ha]);
            u_master.rbyte(1'b0, r);
            chk(r, mem[4'h0]);
            u_master.stop();
            chk({6'h0, sda_oe_o, busy}, 8'h00);
            // current-address read picks up the advanced pointer
            u_master.start();
            send(SR, 1'b1);
            u_master.rbyte(1'b0, r);
            chk(r, mem[4'h1]);
            u_master.stop();
        end
        // lock again and try to overwrite
        wr(`REG_WRITE_ENABLE_CONTROL, 8'h00);
        chk({7'h0, fse}, 8'h00);
        wr(`REG_FEATURE_SET_CONFIG, ~v0);
        chk(fsc, v0);
        // unlock, then reset mid-run: protection returns as at power-up
        wr(`REG_WRITE_ENABLE_CONTROL, 8'h80);
        chk({7'h0, fse}, 8'h01);
        u_master.w(1);
        sys_rst_i = 1'b1;
        u_master.w(2);
        sys_rst_i = 1'b0;
        u_master.w(4);
        chk({6'h0, fse, busy}, 8'h00);
        chk(fsc, 8'h00);
        print_verdict();
    end
endmodule
